// File: rtl/lesm_pkg.sv
// Purpose: Shared constants and types for the lane error and sync monitor.
// Assumes: Eight lanes, byte-wide register port, 12-bit register addresses.
// Notes: Named constants and the one-hot sync state type only.
package lesm_pkg;
   // Structure.
   localparam int LESM_LANES = 8;
   localparam int LESM_CNT_W = 8;
   localparam int LESM_TYPES = 3;
   localparam int LESM_HALF = 4;

   // Register offsets.
   localparam logic [11:0] LESM_ADDR_READBACK = 12'h46b;
   localparam logic [11:0] LESM_ADDR_DISP = 12'h46d;
   localparam logic [11:0] LESM_ADDR_MISS = 12'h46e;
   localparam logic [11:0] LESM_ADDR_STRAY = 12'h46f;
   localparam logic [11:0] LESM_ADDR_CGS = 12'h470;
   localparam logic [11:0] LESM_ADDR_FS = 12'h471;
   localparam logic [11:0] LESM_ADDR_CKS = 12'h472;

   // Field positions of the error control registers.
   localparam int LESM_BIT_CLR_IRQ = 7;
   localparam int LESM_BIT_STOP = 6;
   localparam int LESM_BIT_CLR_CNT = 5;
   localparam int LESM_LANE_HI = 2;
   localparam int LESM_LANE_LO = 0;

   // Field positions of the counter readback selection.
   localparam int LESM_RB_LANE_HI = 6;
   localparam int LESM_RB_LANE_LO = 4;
   localparam int LESM_RB_CNT_HI = 1;
   localparam int LESM_RB_CNT_LO = 0;

   // Positions of the sync interrupt flags.
   localparam int LESM_IRQ_CGS = 0;
   localparam int LESM_IRQ_FS = 1;
   localparam int LESM_IRQ_CKS = 2;

   // Counter type codes.
   localparam logic [1:0] LESM_CNT_DISP = 2'h0;
   localparam logic [1:0] LESM_CNT_MISS = 2'h1;
   localparam logic [1:0] LESM_CNT_STRAY = 2'h2;

   // Reset values.
   localparam logic [7:0] LESM_REG_RST = 8'h00;
   localparam logic [7:0] LESM_LOCK_RST = 8'h00;

   // Resynchronisation states, one-hot.
   typedef enum logic [1:0] {
      LESM_ST_LOCKED = 2'b01,
      LESM_ST_REQUEST = 2'b10
   } lesm_sync_state_t;
endpackage

// File: rtl/lesm_err_counter.sv
// Purpose: One lane's error counter with stop, clear and threshold interrupt.
// Assumes: err_i is a one-cycle strobe per received character in error.
// Notes: The count saturates instead of wrapping so a flood never hides.
`timescale 1ns/1ps
module lesm_err_counter import lesm_pkg::*; #(
   parameter int CNT_W = LESM_CNT_W
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Events and controls.
   input wire logic err_i,
   input wire logic stop_i,
   input wire logic clear_i,
   input wire logic clear_irq_i,
   input wire logic [CNT_W-1:0] limit_i,
   // Results.
   output logic [CNT_W-1:0] count_o,
   output logic over_o,
   output logic irq_o
);
   logic stopped_reg;
   logic [CNT_W-1:0] count_reg;
   logic over_reg;
   logic irq_reg;
   logic over_next;

   // Stop is sticky until reset so a noisy lane cannot creep back in.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         stopped_reg <= 1'b0;
      end else if (stop_i) begin
         stopped_reg <= 1'b1; // RULE2
      end
   end

   // Count one per errored character while running; clear wins over count.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         count_reg <= '0;
      end else if (clear_i) begin
         count_reg <= '0; // RULE3
      end else if (err_i && !stopped_reg && (count_reg != {CNT_W{1'b1}})) begin
         count_reg <= count_reg + 1'b1; // RULE19
      end
   end

   // Threshold flag follows the count.
   assign over_next = (count_reg >= limit_i);
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         over_reg <= 1'b0;
      end else begin
         over_reg <= over_next;
      end
   end

   // A new threshold hit wins over a clear.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         irq_reg <= 1'b0;
      end else if (over_next && !over_reg) begin
         irq_reg <= 1'b1;
      end else if (clear_irq_i) begin
         irq_reg <= 1'b0; // RULE1
      end
   end

   assign count_o = count_reg;
   assign over_o = over_reg;
   assign irq_o = irq_reg;
endmodule

// File: rtl/lesm_resync.sv
// Purpose: Drives the sync request toward the transmitter from lane lock state.
// Assumes: Lock inputs are synchronous levels from the lane receivers.
// Notes: The request is held until every active lane regains code-group lock.
`timescale 1ns/1ps
module lesm_resync import lesm_pkg::*; #(
   parameter int LANES = LESM_LANES
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Lane state.
   input wire logic [LANES-1:0] lane_active_i,
   input wire logic [LANES-1:0] code_group_locked_i,
   input wire logic [LANES-1:0] frame_locked_i,
   // Link control.
   output logic sync_req_n_o,
   output logic resync_start_o
);
   lesm_sync_state_t state_reg;
   lesm_sync_state_t state_next;
   logic [LANES-1:0] frame_prev_reg;
   logic sync_req_n_reg;
   logic start_reg;
   logic cg_lost;
   logic frame_lost;
   logic all_locked;

   assign cg_lost = |(lane_active_i & ~code_group_locked_i);
   assign frame_lost = |(lane_active_i & frame_prev_reg & ~frame_locked_i);
   assign all_locked = (lane_active_i & ~code_group_locked_i) == '0;

   // Falling edge of frame lock only; it is low after release.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         frame_prev_reg <= '0;
      end else begin
         frame_prev_reg <= frame_locked_i;
      end
   end

   // Next state.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LESM_ST_LOCKED: begin
            if (cg_lost || frame_lost) begin
               state_next = LESM_ST_REQUEST; // RULE13 RULE15
            end
         end
         LESM_ST_REQUEST: begin
            if (all_locked) begin
               state_next = LESM_ST_LOCKED;
            end
         end
         default: begin
            state_next = LESM_ST_REQUEST;
         end
      endcase
   end

   // State, request level and start pulse.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg <= LESM_ST_REQUEST;
         sync_req_n_reg <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sync_req_n_reg <= (state_next == LESM_ST_LOCKED); // RULE13
         start_reg <= (state_reg == LESM_ST_LOCKED) && (state_next == LESM_ST_REQUEST);
      end
   end

   assign sync_req_n_o = sync_req_n_reg;
   assign resync_start_o = start_reg;
endmodule

// File: rtl/lesm_monitor.sv
// Purpose: Per-lane error counting, threshold flags and sync status registers.
// Assumes: Byte-wide register port; reads return data one cycle later.
// Notes: Error limit and interrupt enables arrive as plain inputs.
//
// How it works
// RULE1: Disparity bit 7 write clears the addressed lane's interrupt.
// RULE2: Disparity bit 6 write stops the addressed lane's counter.
// RULE3: Disparity bit 5 write zeroes the addressed lane's counter.
// RULE4: Disparity register reads one threshold flag per lane.
// RULE5: Dual link: flag registers show four lanes in the low bits.
// RULE6: Flag registers hold flags only; counts come from the readback.
// RULE7: Table-miss and stray-control registers share these controls.
// RULE8: Bits 2..0 pick the lane for the write-one controls.
// RULE9: Table-miss register reads one threshold flag per lane.
// RULE10: Code-group register reads one lock bit per lane.
// RULE11: A sync register bit 7 write clears its interrupt.
// RULE12: Code-group interrupt flag sits at position 0.
// RULE13: Loss of code-group lock asserts the sync request.
// RULE14: Frame register reads per-lane frame lock as registered one cycle earlier.
// RULE15: Loss of frame lock starts resynchronisation by itself.
// RULE16: Checksum register reads per-lane good checksum; its interrupt sits at position 2.
// RULE17: Enabled disparity threshold drives the interrupt output low.
// RULE18: Software picks lane and counter before reading the count.
// RULE19: Counters count each errored character and hold while stopped.
`timescale 1ns/1ps
module lesm_monitor import lesm_pkg::*; #(
   parameter int LANES = LESM_LANES,
   parameter int CNT_W = LESM_CNT_W
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register port.
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Per-lane error strobes.
   input wire logic [LANES-1:0] disp_err_i,
   input wire logic [LANES-1:0] table_miss_i,
   input wire logic [LANES-1:0] stray_control_i,
   // Per-lane status.
   input wire logic [LANES-1:0] lane_active_i,
   input wire logic [LANES-1:0] code_group_locked_i,
   input wire logic [LANES-1:0] frame_locked_i,
   input wire logic [LANES-1:0] config_sum_ok_i,
   // Configuration.
   input wire logic [CNT_W-1:0] error_limit_i,
   input wire logic disparity_irq_enable_i,
   input wire logic table_miss_irq_enable_i,
   input wire logic stray_control_irq_enable_i,
   input wire logic dual_link_i,
   input wire logic link_pick_i,
   // Outputs.
   output logic irq_n_o,
   output logic [2:0] sync_irq_o,
   output logic sync_req_n_o,
   output logic resync_start_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Write decode.

   logic [LESM_TYPES-1:0] ctl_hit;
   logic [2:0] lane_sel;
   logic [LANES-1:0] lane_onehot;
   logic [LESM_TYPES-1:0][LANES-1:0] clr_irq;
   logic [LESM_TYPES-1:0][LANES-1:0] stop_cnt;
   logic [LESM_TYPES-1:0][LANES-1:0] clr_cnt;
   logic [LESM_TYPES-1:0][LANES-1:0] err_bus;

   // One decode serves all three error control registers.
   assign ctl_hit[LESM_CNT_DISP] = reg_wr_i && (reg_addr_i == LESM_ADDR_DISP);
   assign ctl_hit[LESM_CNT_MISS] = reg_wr_i && (reg_addr_i == LESM_ADDR_MISS); // RULE7
   assign ctl_hit[LESM_CNT_STRAY] = reg_wr_i && (reg_addr_i == LESM_ADDR_STRAY); // RULE7
   assign lane_sel = reg_wdata_i[LESM_LANE_HI:LESM_LANE_LO]; // RULE8

   // Error strobes grouped by counter type code.
   assign err_bus[LESM_CNT_DISP] = disp_err_i;
   assign err_bus[LESM_CNT_MISS] = table_miss_i;
   assign err_bus[LESM_CNT_STRAY] = stray_control_i;

   ////////////////////////////////////////////////////////////////////////////
   // Counters, one per lane and error type.

   logic [CNT_W-1:0] cnt_all [LESM_TYPES][LANES];
   logic [LESM_TYPES-1:0][LANES-1:0] over_all;
   logic [LESM_TYPES-1:0][LANES-1:0] irq_all;

   genvar gl;
   genvar gt;
   generate
      for (gl = 0; gl < LANES; gl++) begin : g_lane
         // Lane address compare shared by every type.
         assign lane_onehot[gl] = (lane_sel == 3'(gl)); // RULE8
         for (gt = 0; gt < LESM_TYPES; gt++) begin : g_type
            assign clr_irq[gt][gl] = ctl_hit[gt] && lane_onehot[gl]
               && reg_wdata_i[LESM_BIT_CLR_IRQ]; // RULE1 RULE7
            assign stop_cnt[gt][gl] = ctl_hit[gt] && lane_onehot[gl]
               && reg_wdata_i[LESM_BIT_STOP]; // RULE2 RULE7
            assign clr_cnt[gt][gl] = ctl_hit[gt] && lane_onehot[gl]
               && reg_wdata_i[LESM_BIT_CLR_CNT]; // RULE3 RULE7
            lesm_err_counter #(
               .CNT_W(CNT_W)
            ) u_cnt (
               .clk_i(clk_i),
               .resetn_i(resetn_i),
               .err_i(err_bus[gt][gl]),
               .stop_i(stop_cnt[gt][gl]),
               .clear_i(clr_cnt[gt][gl]),
               .clear_irq_i(clr_irq[gt][gl]),
               .limit_i(error_limit_i),
               .count_o(cnt_all[gt][gl]),
               .over_o(over_all[gt][gl]),
               .irq_o(irq_all[gt][gl])
            );
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Counter readback selection.

   logic [2:0] rb_lane_reg;
   logic [1:0] rb_cnt_reg;

   // Selection must be written before the count is read back.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rb_lane_reg <= LESM_REG_RST[2:0];
         rb_cnt_reg <= LESM_REG_RST[1:0];
      end else if (reg_wr_i && (reg_addr_i == LESM_ADDR_READBACK)) begin
         rb_lane_reg <= reg_wdata_i[LESM_RB_LANE_HI:LESM_RB_LANE_LO]; // RULE18
         rb_cnt_reg <= reg_wdata_i[LESM_RB_CNT_HI:LESM_RB_CNT_LO]; // RULE18
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sync status interrupts.

   logic [LANES-1:0] cg_prev_reg;
   logic [LANES-1:0] fs_prev_reg;
   logic [LANES-1:0] cks_prev_reg;
   logic [2:0] sync_irq_reg;
   logic [2:0] sync_set;
   logic [2:0] sync_clr;

   // Previous lock levels for falling-edge detection.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cg_prev_reg <= LESM_LOCK_RST;
         fs_prev_reg <= LESM_LOCK_RST;
         cks_prev_reg <= LESM_LOCK_RST;
      end else begin
         cg_prev_reg <= code_group_locked_i;
         fs_prev_reg <= frame_locked_i;
         cks_prev_reg <= config_sum_ok_i;
      end
   end

   // A lost lock or checksum on any active lane raises its flag.
   assign sync_set[LESM_IRQ_CGS] = |(lane_active_i & cg_prev_reg & ~code_group_locked_i);
   assign sync_set[LESM_IRQ_FS] = |(lane_active_i & fs_prev_reg & ~frame_locked_i);
   assign sync_set[LESM_IRQ_CKS] = |(lane_active_i & cks_prev_reg & ~config_sum_ok_i);
   // The three sync registers sit at consecutive offsets in flag order.
   genvar gs;
   generate
      for (gs = 0; gs < $bits(sync_clr); gs++) begin : g_sync_clr
         assign sync_clr[gs] = reg_wr_i && (reg_addr_i == 12'(LESM_ADDR_CGS + gs))
            && reg_wdata_i[LESM_BIT_CLR_IRQ]; // RULE11
      end
   endgenerate

   // Sticky flags; a new event in the clearing cycle is kept. RULE12 RULE16
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sync_irq_reg <= LESM_REG_RST[2:0];
      end else begin
         sync_irq_reg <= sync_set | (sync_irq_reg & ~sync_clr); // RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt output.

   logic irq_n_reg;

   // Pulled low while any enabled threshold interrupt is pending.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= !((disparity_irq_enable_i && |irq_all[LESM_CNT_DISP]) // RULE17
            || (table_miss_irq_enable_i && |irq_all[LESM_CNT_MISS])
            || (stray_control_irq_enable_i && |irq_all[LESM_CNT_STRAY]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data.

   // In dual link mode each link sees only its own four lanes in the low bits.
   function automatic logic [7:0] link_view(input logic [7:0] flags);
      logic [7:0] v;
      v = flags;
      if (dual_link_i) begin
         v = link_pick_i ? {4'h0, flags[7:LESM_HALF]} : {4'h0, flags[LESM_HALF-1:0]}; // RULE5
      end
      return v;
   endfunction

   logic [7:0] rdata_next;
   logic [7:0] rdata_reg;

   // Flag registers carry flags only; counts come through the readback. RULE6
   always_comb begin
      rdata_next = LESM_REG_RST;
      case (reg_addr_i)
         LESM_ADDR_READBACK: begin
            if (rb_cnt_reg <= LESM_CNT_STRAY) begin
               rdata_next = cnt_all[rb_cnt_reg][rb_lane_reg][7:0]; // RULE6
            end
         end
         LESM_ADDR_DISP: begin
            rdata_next = link_view(over_all[LESM_CNT_DISP]); // RULE4
         end
         LESM_ADDR_MISS: begin
            rdata_next = link_view(over_all[LESM_CNT_MISS]); // RULE9
         end
         LESM_ADDR_STRAY: begin
            rdata_next = link_view(over_all[LESM_CNT_STRAY]);
         end
         LESM_ADDR_CGS: begin
            rdata_next = link_view(cg_prev_reg); // RULE10
         end
         LESM_ADDR_FS: begin
            rdata_next = link_view(fs_prev_reg); // RULE14
         end
         LESM_ADDR_CKS: begin
            rdata_next = link_view(cks_prev_reg); // RULE16
         end
         default: begin
            rdata_next = LESM_REG_RST;
         end
      endcase
   end

   // Read data is registered and holds until the next read.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_reg <= LESM_REG_RST;
      end else if (reg_rd_i) begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Resynchronisation.

   logic sync_req_n_w;
   logic resync_start_w;

   lesm_resync #(
      .LANES(LANES)
   ) u_resync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .lane_active_i(lane_active_i),
      .code_group_locked_i(code_group_locked_i),
      .frame_locked_i(frame_locked_i),
      .sync_req_n_o(sync_req_n_w),
      .resync_start_o(resync_start_w)
   );

   assign reg_rdata_o = rdata_reg;
   assign irq_n_o = irq_n_reg;
   assign sync_irq_o = sync_irq_reg;
   assign sync_req_n_o = sync_req_n_w;
   assign resync_start_o = resync_start_w;
endmodule

// File: verification/lesm_monitor_checker.sv
// Purpose: Port-level assertions for the lane error and sync monitor.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes: Bound at the foot of the file.
`timescale 1ns/1ps
module lesm_monitor_checker import lesm_pkg::*; #(
   parameter int LANES = LESM_LANES
) (
   // Clock, reset and register port.
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Lane state and configuration.
   input wire logic [LANES-1:0] lane_active_i,
   input wire logic [LANES-1:0] code_group_locked_i,
   input wire logic [LANES-1:0] frame_locked_i,
   input wire logic [LANES-1:0] config_sum_ok_i,
   input wire logic disparity_irq_enable_i,
   input wire logic table_miss_irq_enable_i,
   input wire logic stray_control_irq_enable_i,
   input wire logic dual_link_i,
   // Outputs watched.
   input wire logic irq_n_o,
   input wire logic [2:0] sync_irq_o,
   input wire logic sync_req_n_o,
   input wire logic resync_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Helper terms.
   wire logic cg_lost = |(lane_active_i & ~code_group_locked_i);
   wire logic quiet = !disparity_irq_enable_i && !table_miss_irq_enable_i
      && !stray_control_irq_enable_i;
   wire logic mapped = reg_addr_i >= LESM_ADDR_READBACK && reg_addr_i <= LESM_ADDR_CKS
      && reg_addr_i != 12'h46c;

   a_req_on_loss: assert property (cg_lost ##1 cg_lost |=> !sync_req_n_o)
      else $error("sync request missing after lock loss");
   a_frame_resync: assert property (sync_req_n_o &&
      |(lane_active_i & $past(frame_locked_i) & ~frame_locked_i) |-> ##[1:2] resync_start_o)
      else $error("no resync after frame loss");
   a_resync_pulse: assert property (resync_start_o |-> !sync_req_n_o ##1 !resync_start_o)
      else $error("resync start not a single pulse with request");
   a_irq_masked: assert property (quiet ##1 quiet |-> irq_n_o)
      else $error("interrupt low with all enables off");
   a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_lock_read: assert property (reg_rd_i && reg_addr_i == LESM_ADDR_CGS && !dual_link_i
      && $stable(code_group_locked_i) && $past(resetn_i)
      |=> reg_rdata_o == $past(code_group_locked_i))
      else $error("code-group read differs from lock inputs");
   a_cgs_flag: assert property ($past(resetn_i) &&
      |(lane_active_i & $past(code_group_locked_i) & ~code_group_locked_i)
      |-> ##[1:2] sync_irq_o[0])
      else $error("code-group loss flag not set");
   a_sum_flag: assert property ($past(resetn_i) &&
      |(lane_active_i & $past(config_sum_ok_i) & ~config_sum_ok_i) |-> ##[1:2] sync_irq_o[2])
      else $error("checksum loss flag not set");
endmodule

bind lesm_monitor lesm_monitor_checker #(.LANES(LANES)) chk_u (
   .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .lane_active_i(lane_active_i),
   .code_group_locked_i(code_group_locked_i), .frame_locked_i(frame_locked_i),
   .config_sum_ok_i(config_sum_ok_i), .disparity_irq_enable_i(disparity_irq_enable_i),
   .table_miss_irq_enable_i(table_miss_irq_enable_i),
   .stray_control_irq_enable_i(stray_control_irq_enable_i), .dual_link_i(dual_link_i),
   .irq_n_o(irq_n_o), .sync_irq_o(sync_irq_o), .sync_req_n_o(sync_req_n_o),
   .resync_start_o(resync_start_o)
);

// File: verification/lesm_tx_model.sv
// Purpose: Transmitter side of the lanes as seen by the monitor's inputs.
// Assumes: Lock follows three cycles of code-group characters.
// Notes: Drops and error strobes are commanded by the bench.
`timescale 1ns/1ps
module lesm_tx_model (
   // Clock, reset and request.
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sync_req_n_i,
   // Bench commands.
   input wire logic [1:0] err_kind_i,
   input wire logic [7:0] err_lanes_i,
   input wire logic err_send_i,
   input wire logic [7:0] cgs_drop_i,
   input wire logic [7:0] frame_drop_i,
   input wire logic [7:0] sum_bad_i,
   // Lane view.
   output logic [7:0] disp_err_o,
   output logic [7:0] table_miss_o,
   output logic [7:0] stray_control_o,
   output logic [7:0] code_group_locked_o,
   output logic [7:0] frame_locked_o,
   output logic [7:0] config_sum_ok_o
);
   logic [1:0] cgs_cnt_reg;
   logic [7:0] locked_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // Code-group characters flow only while the request is low.
   always_ff @(posedge clk_i) begin
      if (!resetn_i || sync_req_n_i) begin
         cgs_cnt_reg <= 2'h0;
      end else if (cgs_cnt_reg != 2'h3) begin
         cgs_cnt_reg <= cgs_cnt_reg + 2'h1;
      end
   end
   // A dropped lane relocks after a fresh code-group run.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         locked_reg <= 8'h00;
      end else begin
         locked_reg <= (locked_reg | {8{cgs_cnt_reg == 2'h3}}) & ~cgs_drop_i;
      end
   end
   // Status levels and one-cycle error strobes.
   assign code_group_locked_o = locked_reg;
   assign frame_locked_o = locked_reg & ~frame_drop_i;
   assign config_sum_ok_o = ~sum_bad_i;
   assign disp_err_o = (err_send_i && err_kind_i == 2'h0) ? err_lanes_i : 8'h00;
   assign table_miss_o = (err_send_i && err_kind_i == 2'h1) ? err_lanes_i : 8'h00;
   assign stray_control_o = (err_send_i && err_kind_i == 2'h2) ? err_lanes_i : 8'h00;
endmodule

// File: verification/tb_top.sv
// Purpose: Register-level tests of the lane error and sync monitor.
// Assumes: Error limit of three; all lanes active.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module tb_top import lesm_pkg::*; ;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0, rd = 1'b0, send = 1'b0, en = 1'b1, dual = 1'b0, pick = 1'b0;
   logic [1:0] kind = 2'h0;
   logic [7:0] lanes = 8'h00, cdrop = 8'hff, fdrop = 8'h00, sbad = 8'h00;
   logic [7:0] rdata, disp, miss, stray, cgl, fsl, cks;
   logic irq_n, req_n, resync;
   logic [2:0] sirq;
   logic [11:0] ctl;
   logic [2:0] ln;
   int n_mismatch = 0, comparisons = 0, i, k;

   // Design and transmitter model.
   lesm_monitor dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .disp_err_i(disp), .table_miss_i(miss), .stray_control_i(stray),
      .lane_active_i(8'hff), .code_group_locked_i(cgl), .frame_locked_i(fsl),
      .config_sum_ok_i(cks), .error_limit_i(8'h03), .disparity_irq_enable_i(en),
      .table_miss_irq_enable_i(en), .stray_control_irq_enable_i(en), .dual_link_i(dual),
      .link_pick_i(pick), .irq_n_o(irq_n), .sync_irq_o(sirq), .sync_req_n_o(req_n),
      .resync_start_o(resync));
   lesm_tx_model tx_u (.clk_i(clk_i), .resetn_i(resetn_i), .sync_req_n_i(req_n),
      .err_kind_i(kind), .err_lanes_i(lanes), .err_send_i(send), .cgs_drop_i(cdrop),
      .frame_drop_i(fdrop), .sum_bad_i(sbad), .disp_err_o(disp), .table_miss_o(miss),
      .stray_control_o(stray), .code_group_locked_o(cgl), .frame_locked_o(fsl),
      .config_sum_ok_o(cks));

   initial begin
      forever #4 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Bench tasks.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      tick(1);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   endtask
   // Read data is taken just after the edge that registers it.
   task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
      tick(1);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      chk(name, exp, rdata);
   endtask
   task automatic count_chk(input logic [2:0] l, input logic [1:0] t, input logic [7:0] exp);
      wr_reg(LESM_ADDR_READBACK, {1'b0, l, 2'b00, t});
      rd_chk("count", LESM_ADDR_READBACK, exp);
   endtask
   task automatic send_err(input logic [1:0] t, input logic [7:0] m);
      tick(1);
      kind = t;
      lanes = m;
      send = 1'b1;
      tick(1);
      send = 1'b0;
      tick(4);
   endtask
   // A request level that never arrives ends the run.
   task automatic wait_req(input logic v);
      for (int j = 0; j < 40 && req_n !== v; j++) tick(1);
      chk("sync_req_n", 8'(v), 8'(req_n));
      if (req_n !== v) begin
         report_and_stop();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      tick(5);
      resetn_i = 1'b1;
      chk("irq_n", 8'h01, 8'(irq_n));
      for (i = 0; i < 5; i++) rd_chk("reset value", 12'(LESM_ADDR_DISP + i), 8'h00);
      cdrop = 8'h00;
      wait_req(1'b1);
      for (i = 0; i < 3; i++) rd_chk("sync flags", 12'(LESM_ADDR_CGS + i), 8'hff);
      for (k = 0; k < 3; k++) begin
         ctl = 12'(LESM_ADDR_DISP + k);
         ln = 3'(k + 2);
         repeat (3) send_err(2'(k), 8'h01 << ln);
         count_chk(ln, 2'(k), 8'h03);
         rd_chk("flags", ctl, 8'h01 << ln);
         chk("irq_n", 8'h00, 8'(irq_n));
         en = 1'b0;
         tick(3);
         chk("irq_n masked", 8'h01, 8'(irq_n));
         en = 1'b1;
         wr_reg(ctl, 8'h80 | 8'(ln));
         tick(3);
         chk("irq_n cleared", 8'h01, 8'(irq_n));
         wr_reg(ctl, 8'h40 | 8'(ln));
         send_err(2'(k), (8'h01 << ln) | 8'h01);
         count_chk(ln, 2'(k), 8'h03);
         count_chk(3'h0, 2'(k), 8'h01);
         wr_reg(ctl, 8'h20 | 8'(ln));
         count_chk(ln, 2'(k), 8'h00);
         rd_chk("flags cleared", ctl, 8'h00);
      end
      count_chk(3'h0, 2'h3, 8'h00);
      rd_chk("unmapped", 12'h400, 8'h00);
      wr_reg(LESM_ADDR_CGS, 8'h00);
      rd_chk("read only", LESM_ADDR_CGS, 8'hff);
      // Checksum loss with the dual link view.
      sbad = 8'h20;
      tick(3);
      chk("sync_irq", 8'h04, 8'(sirq));
      dual = 1'b1;
      pick = 1'b1;
      rd_chk("upper link", LESM_ADDR_CKS, 8'h0d);
      pick = 1'b0;
      rd_chk("lower link", LESM_ADDR_CKS, 8'h0f);
      dual = 1'b0;
      rd_chk("checksum", LESM_ADDR_CKS, 8'hdf);
      sbad = 8'h00;
      wr_reg(LESM_ADDR_CKS, 8'h80);
      tick(2);
      chk("sync_irq", 8'h00, 8'(sirq));
      // Frame loss restarts synchronisation by itself.
      fdrop = 8'h02;
      for (i = 0; i < 10 && resync !== 1'b1; i++) tick(1);
      chk("resync_start", 8'h01, 8'(resync));
      rd_chk("frame", LESM_ADDR_FS, 8'hfd);
      chk("sync_irq", 8'h02, 8'(sirq));
      fdrop = 8'h00;
      wait_req(1'b1);
      // Code-group loss on one lane.
      cdrop = 8'h04;
      wait_req(1'b0);
      chk("sync_irq cgs", 8'h01, 8'(sirq[0]));
      rd_chk("code group", LESM_ADDR_CGS, 8'hfb);
      cdrop = 8'h00;
      wait_req(1'b1);
      wr_reg(LESM_ADDR_CGS, 8'h80);
      wr_reg(LESM_ADDR_FS, 8'h80);
      tick(2);
      chk("sync_irq", 8'h00, 8'(sirq));
      report_and_stop();
   end
endmodule
